// file: test/tb.sv
// Self-checking bench for the two-wire target transfer block
`timescale 1ns/1ps
`include "twtt_consts.vh"
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    wire [31:0] avsReadData;
    wire avsWaitRequest, sclOut, sclOe, sdaOut, sdaOe, irq, sclLine, sdaLine;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic [6:0] ownAddr;
    logic [7:0] d1, d2, got;
    logic ack;
    localparam logic [31:0] sDir = 32'h1 << `TWTT_ST_READ_DIR;
    localparam logic [31:0] sRx = 32'h1 << `TWTT_ST_RX_FULL;
    localparam logic [31:0] sDone = 32'h1 << `TWTT_ST_XFER_DONE;
    localparam logic [31:0] sAcc = 32'h1 << `TWTT_ST_ACCESS;
    localparam logic [31:0] sWait = 32'h1 << `TWTT_ST_CLK_WAIT;
    localparam logic [31:0] sGc = 32'h1 << `TWTT_ST_GEN_CALL;
    twtt_transfer i_twtt_transfer (.ref_clk(ref_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
    twtt_bus_master u_master (.ref_clk(ref_clk), .sclOe(sclOe & ~sclOut), .sdaOe(sdaOe & ~sdaOut), .sclLine(sclLine),
        .sdaLine(sdaLine));
    always #25 ref_clk = ~ref_clk;
    task automatic report_and_stop();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        compares++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g & m, e & m);
        end
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // Read results are matched against the oldest note
    always @(posedge ref_clk) begin
        if (avsRead && !avsWaitRequest) chk(avsReadData, expQ.pop_front(), mskQ.pop_front());
    end
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge ref_clk);
        while (avsWaitRequest) @(posedge ref_clk);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        bus_xfer(1'b0, a, 32'h0);
    endtask
    initial begin
        void'($urandom(32'h359cbd58));
        ownAddr = 7'h10 | 7'($urandom() % 16);
        d1 = 8'($urandom());
        d2 = 8'($urandom());
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(4'h9, 32'h0, 32'hffffffff);
        rd(`TWTT_REG_STATUS, 32'h0, sAcc | sRx | sWait);
        bus_xfer(1'b1, `TWTT_REG_OWN_ADDR, {25'h0, ownAddr});
        bus_xfer(1'b1, `TWTT_REG_CTRL, 32'h3);
        bus_xfer(1'b1, `TWTT_REG_IRQ_ENABLE, 32'h3f);
        rd(`TWTT_REG_OWN_ADDR, {25'h0, ownAddr}, 32'h7f);
        // Controller write, second byte waits on an unread holding register
        u_master.start_cond();
        u_master.byte_out({ownAddr, 1'b0}, ack);
        chk({31'h0, ack}, 32'h0, 32'h1);
        rd(`TWTT_REG_STATUS, sAcc, sAcc | sDir);
        u_master.byte_out(d1, ack);
        rd(`TWTT_REG_STATUS, sRx, sRx);
        fork
            u_master.byte_out(d2, ack);
            begin
                while (!sclOe) @(posedge ref_clk);
                rd(`TWTT_REG_STATUS, sWait | sRx, sWait | sRx);
                rd(`TWTT_REG_RX_HOLD, {24'h0, d1}, 32'hff);
            end
        join
        rd(`TWTT_REG_RX_HOLD, {24'h0, d2}, 32'hffffffff);
        rd(`TWTT_REG_STATUS, 32'h0, sRx | sWait);
        u_master.stop_cond();
        rd(`TWTT_REG_STATUS, sDone, sDone | sAcc);
        chk({31'h0, irq}, 32'h1, 32'h1);
        bus_xfer(1'b1, `TWTT_REG_IRQ_CLEAR, 32'h3f);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        // Foreign address is not acknowledged
        u_master.start_cond();
        u_master.byte_out({ownAddr ^ 7'h01, 1'b0}, ack);
        chk({31'h0, ack}, 32'h1, 32'h1);
        rd(`TWTT_REG_STATUS, 32'h0, sAcc);
        u_master.stop_cond();
        // Controller read, each byte waits for software to load it
        u_master.start_cond();
        u_master.byte_out({ownAddr, 1'b1}, ack);
        chk({31'h0, ack}, 32'h0, 32'h1);
        rd(`TWTT_REG_STATUS, sAcc | sDir, sAcc | sDir);
        for (int i = 0; i < 2; i++) begin
            fork
                u_master.byte_in(i == 1, got);
                begin
                    while (!sclOe) @(posedge ref_clk);
                    rd(`TWTT_REG_STATUS, sWait, sWait);
                    bus_xfer(1'b1, `TWTT_REG_TX_HOLD, {24'h0, (i == 1) ? d2 : d1});
                end
            join
            chk({24'h0, got}, {24'h0, (i == 1) ? d2 : d1}, 32'hff);
        end
        u_master.start_cond();
        u_master.byte_out({ownAddr ^ 7'h01, 1'b1}, ack);
        rd(`TWTT_REG_STATUS, 32'h0, sAcc);
        u_master.stop_cond();
        // General call refused while its enable is off
        bus_xfer(1'b1, `TWTT_REG_CTRL, 32'h1);
        u_master.start_cond();
        u_master.byte_out(8'h00, ack);
        chk({31'h0, ack}, 32'h1, 32'h1);
        rd(`TWTT_REG_STATUS, 32'h0, sGc | sAcc);
        u_master.stop_cond();
        bus_xfer(1'b1, `TWTT_REG_CTRL, 32'h3);
        // General call with its interrupt masked, then unmasked
        bus_xfer(1'b1, `TWTT_REG_IRQ_CLEAR, 32'h3f);
        bus_xfer(1'b1, `TWTT_REG_IRQ_ENABLE, 32'h0);
        u_master.start_cond();
        u_master.byte_out(8'h00, ack);
        chk({31'h0, ack}, 32'h0, 32'h1);
        rd(`TWTT_REG_STATUS, sGc, sGc);
        chk({31'h0, irq}, 32'h0, 32'h1);
        rd(`TWTT_REG_IRQ_STATUS, 32'h1 << `TWTT_EV_GEN_CALL, 32'h1 << `TWTT_EV_GEN_CALL);
        bus_xfer(1'b1, `TWTT_REG_IRQ_ENABLE, 32'h3f);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        // Software takes a new address from the general call data
        u_master.byte_out(d2, ack);
        rd(`TWTT_REG_RX_HOLD, {24'h0, d2}, 32'hff);
        u_master.stop_cond();
        bus_xfer(1'b1, `TWTT_REG_OWN_ADDR, {25'h0, d2[7:1]});
        u_master.start_cond();
        u_master.byte_out({d2[7:1], 1'b0}, ack);
        chk({31'h0, ack}, 32'h0, 32'h1);
        u_master.stop_cond();
        report_and_stop();
    end
endmodule

// file: test/twtt_bus_master.sv
// Two-wire bus controller model on pulled-up lines
`timescale 1ns/1ps
module twtt_bus_master (
    input wire logic ref_clk, // Clock
    input wire logic sclOe, // Target clock pull
    input wire logic sdaOe, // Target data pull
    output wire logic sclLine, // Clock line
    output wire logic sdaLine // Data line
);
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;
    // Released lines float to the pull-up level
    assign sclLine = sclDrv & ~sclOe;
    assign sdaLine = sdaDrv & ~sdaOe;
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data set early in the low phase, sampled late in the high phase
    // Eight cycles a bit, six low and two high: 400 ns
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sdaDrv <= b;
        tick(4);
        sclDrv <= 1'b1;
        tick(1);
        while (!sclLine) tick(1);
        tick(1);
        r = sdaLine;
        sclDrv <= 1'b0;
    endtask
    task automatic start_cond();
        tick(2);
        sdaDrv <= 1'b1;
        tick(6);
        sclDrv <= 1'b1;
        tick(6);
        sdaDrv <= 1'b0;
        tick(6);
        sclDrv <= 1'b0;
    endtask
    task automatic stop_cond();
        tick(2);
        sdaDrv <= 1'b0;
        tick(6);
        sclDrv <= 1'b1;
        tick(6);
        sdaDrv <= 1'b1;
        tick(6);
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
        bit_io(1'b1, ack);
    endtask
    task automatic byte_in(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// file: test/twtt_transfer_properties.sv
// Port checker for the two-wire target transfer block
`timescale 1ns/1ps
`include "twtt_consts.vh"
module twtt_transfer_properties (
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [3:0] avsAddress, // Address
    input wire logic avsRead, // Read
    input wire logic avsWrite, // Write
    input wire logic [31:0] avsWriteData, // Write data
    input wire logic [31:0] avsReadData, // Read data
    input wire logic avsWaitRequest, // Wait
    input wire logic sclIn, // Clock line
    input wire logic sclOut, // Clock out
    input wire logic sclOe, // Clock pull
    input wire logic sdaIn, // Data line
    input wire logic sdaOut, // Data out
    input wire logic sdaOe, // Data pull
    input wire logic irq // Interrupt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire rdDone = avsRead && !avsWaitRequest;
    wire wrDone = avsWrite && !avsWaitRequest;
    read_wait_a: assert property ($rose(avsRead) |-> avsWaitRequest ##1 !avsWaitRequest)
        else $error("read wait cycle wrong");
    write_wait_a: assert property ($rose(avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
        else $error("write wait cycle wrong");
    unmapped_zero_a: assert property (rdDone && avsAddress[3] |-> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    rxhold_upper_a: assert property (rdDone && avsAddress == `TWTT_REG_RX_HOLD |-> avsReadData[31:8] == 24'h0)
        else $error("receive word upper bits set");
    stretch_low_a: assert property ($rose(sclOe) |-> !$past(sclIn))
        else $error("clock hold began while clock high");
    rx_release_a: assert property (sclOe && rdDone && avsAddress == `TWTT_REG_RX_HOLD |-> ##[1:8] !sclOe)
        else $error("clock not released after receive read");
    tx_release_a: assert property (sclOe && wrDone && avsAddress == `TWTT_REG_TX_HOLD |-> ##[1:8] !sclOe)
        else $error("clock not released after transmit write");
    sda_setup_a: assert property ($changed(sdaOe) |-> !$past(sclIn))
        else $error("data changed while clock high");
    cover property ($rose(sclOe));
    cover property (rdDone && avsAddress == `TWTT_REG_RX_HOLD);
    cover property ($rose(irq));
endmodule
bind twtt_transfer twtt_transfer_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));

// file: verilog/twtt_consts.vh
// Constants for the two-wire target transfer block
`ifndef TWTT_CONSTS_VH
`define TWTT_CONSTS_VH

// Register word indexes on the Avalon-MM slave
`define TWTT_REG_CTRL 4'h0
`define TWTT_REG_OWN_ADDR 4'h1
`define TWTT_REG_STATUS 4'h2
`define TWTT_REG_RX_HOLD 4'h3
`define TWTT_REG_TX_HOLD 4'h4
`define TWTT_REG_IRQ_STATUS 4'h5
`define TWTT_REG_IRQ_ENABLE 4'h6
`define TWTT_REG_IRQ_CLEAR 4'h7

// Control register fields
`define TWTT_CTRL_ENABLE 0
`define TWTT_CTRL_GC_ENABLE 1
`define TWTT_CTRL_RESET 2'h0
`define TWTT_OWN_ADDR_RESET 7'h00

// Status register fields
`define TWTT_ST_READ_DIR 0
`define TWTT_ST_RX_FULL 1
`define TWTT_ST_TX_EMPTY 2
`define TWTT_ST_XFER_DONE 3
`define TWTT_ST_ACCESS 4
`define TWTT_ST_CLK_WAIT 5
`define TWTT_ST_GEN_CALL 6

// Interrupt event bits
`define TWTT_EV_RX_FULL 0
`define TWTT_EV_TX_EMPTY 1
`define TWTT_EV_XFER_DONE 2
`define TWTT_EV_ACCESS 3
`define TWTT_EV_GEN_CALL 4
`define TWTT_EV_CLK_WAIT 5
`define TWTT_EV_WIDTH 6

// General call address
`define TWTT_GEN_CALL_ADDR 7'h00

`endif

// file: verilog/twtt_line_sync.v
// Three-stage pin synchroniser with bus condition detection
`timescale 1ns/1ps
module twtt_line_sync (
    input wire ref_clk, // 20 MHz block clock
    input wire sys_rst, // Synchronous reset, active high
    input wire sclIn, // Serial clock pin level
    input wire sdaIn, // Serial data pin level
    output reg sclLvl, // Filtered clock level
    output reg sdaLvl, // Filtered data level
    output wire sclRise, // Clock rising, one cycle
    output wire sclFall, // Clock falling, one cycle
    output wire startDet, // START or repeated START, one cycle
    output wire stopDet // STOP, one cycle
);
    reg sclS1_reg;
    reg sclS2_reg;
    reg sclS3_reg;
    reg sdaS1_reg;
    reg sdaS2_reg;
    reg sdaS3_reg;
    reg sclPrev_reg;
    reg sdaPrev_reg;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sclS1_reg <= 1'b1;
            sclS2_reg <= 1'b1;
            sclS3_reg <= 1'b1;
            sdaS1_reg <= 1'b1;
            sdaS2_reg <= 1'b1;
            sdaS3_reg <= 1'b1;
            sclLvl <= 1'b1;
            sdaLvl <= 1'b1;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclS1_reg <= sclIn;
            sclS2_reg <= sclS1_reg;
            sclS3_reg <= sclS2_reg;
            sdaS1_reg <= sdaIn;
            sdaS2_reg <= sdaS1_reg;
            sdaS3_reg <= sdaS2_reg;
            // A change counts once stages two and three agree
            if (sclS2_reg == sclS3_reg) begin
                sclLvl <= sclS3_reg;
            end
            if (sdaS2_reg == sdaS3_reg) begin
                sdaLvl <= sdaS3_reg;
            end
            sclPrev_reg <= sclLvl;
            sdaPrev_reg <= sdaLvl;
        end
    end

    assign sclRise = sclLvl & ~sclPrev_reg;
    assign sclFall = ~sclLvl & sclPrev_reg;
    assign startDet = sclLvl & sclPrev_reg & sdaPrev_reg & ~sdaLvl;
    assign stopDet = sclLvl & sclPrev_reg & ~sdaPrev_reg & sdaLvl;
endmodule

// file: verilog/twtt_transfer.v
// Two-wire target transfer logic with Avalon-MM register slave
`timescale 1ns/1ps
`include "twtt_consts.vh"

module twtt_transfer (
    input wire ref_clk, // 20 MHz block clock
    input wire sys_rst, // Synchronous reset, active high
    input wire [3:0] avsAddress, // Avalon word address
    input wire avsRead, // Avalon read request
    input wire avsWrite, // Avalon write request
    input wire [31:0] avsWriteData, // Avalon write data
    output reg [31:0] avsReadData, // Avalon read data
    output wire avsWaitRequest, // Avalon wait request
    input wire sclIn, // Serial clock pin input
    output wire sclOut, // Serial clock pin output value
    output wire sclOe, // Serial clock pull-low enable
    input wire sdaIn, // Serial data pin input
    output wire sdaOut, // Serial data pin output value
    output wire sdaOe, // Serial data pull-low enable
    output wire irq // Level interrupt
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK = 3'h2;
    localparam [2:0] ST_RX = 3'h3;
    localparam [2:0] ST_TXLOAD = 3'h4;
    localparam [2:0] ST_TX = 3'h5;
    localparam [2:0] ST_TXACK = 3'h6;
    localparam [2:0] ST_WAITEND = 3'h7;

    wire sclLvl;
    wire sdaLvl;
    wire sclRise;
    wire sclFall;
    wire startDet;
    wire stopDet;

    reg [1:0] ctrl_reg;
    reg [6:0] ownAddr_reg;
    reg [7:0] rxHold_reg;
    reg [7:0] txHold_reg;
    reg rxFull_reg;
    reg txFull_reg;
    reg readDir_reg;
    reg access_reg;
    reg xferDone_reg;
    reg clkWait_reg;
    reg genCall_reg;
    reg [`TWTT_EV_WIDTH-1:0] irqStatus_reg;
    reg [`TWTT_EV_WIDTH-1:0] irqEnable_reg;
    reg [`TWTT_EV_WIDTH-1:0] evPrev_reg;
    reg [2:0] state_reg;
    reg [7:0] shift_reg;
    reg [2:0] bitCnt_reg;
    reg ackOn_reg;
    reg rxPend_reg;
    reg masterNack_reg;
    reg sclDrive_reg;
    reg sdaDrive_reg;
    reg phase_reg;

    wire busReq;
    wire busDone;
    wire rdRxHold;
    wire wrTxHold;
    wire [7:0] statusBits;
    wire [`TWTT_EV_WIDTH-1:0] evNow;
    wire [`TWTT_EV_WIDTH-1:0] evRise;
    wire [`TWTT_EV_WIDTH-1:0] irqClear;

    twtt_line_sync lineSync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sclLvl(sclLvl),
        .sdaLvl(sdaLvl),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // Address compare used for own address and general call
    function addrHit;
        input [6:0] got;
        input [6:0] want;
        begin
            addrHit = (got == want);
        end
    endfunction

    // One wait cycle, then the access completes
    assign busReq = avsRead | avsWrite;
    assign avsWaitRequest = busReq & ~phase_reg;
    assign busDone = busReq & phase_reg;
    assign rdRxHold = busDone & avsRead & (avsAddress == `TWTT_REG_RX_HOLD);
    assign wrTxHold = busDone & avsWrite & (avsAddress == `TWTT_REG_TX_HOLD);
    assign irqClear = (busDone & avsWrite & (avsAddress == `TWTT_REG_IRQ_CLEAR)) ?
        avsWriteData[`TWTT_EV_WIDTH-1:0] : {`TWTT_EV_WIDTH{1'b0}};

    assign statusBits = {1'b0, genCall_reg, clkWait_reg, access_reg, xferDone_reg,
        ~txFull_reg, rxFull_reg, readDir_reg};

    assign evNow = {clkWait_reg, genCall_reg, access_reg, xferDone_reg,
        ~txFull_reg & access_reg & readDir_reg, rxFull_reg};
    assign evRise = evNow & ~evPrev_reg;
    assign irq = |(irqStatus_reg & irqEnable_reg);

    // Open-drain pins only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclDrive_reg;
    assign sdaOe = sdaDrive_reg;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= 1'b0;
            avsReadData <= 32'h00000000;
            ctrl_reg <= `TWTT_CTRL_RESET;
            ownAddr_reg <= `TWTT_OWN_ADDR_RESET;
            irqEnable_reg <= {`TWTT_EV_WIDTH{1'b0}};
            irqStatus_reg <= {`TWTT_EV_WIDTH{1'b0}};
            evPrev_reg <= {`TWTT_EV_WIDTH{1'b0}};
        end else begin
            phase_reg <= busReq & ~phase_reg;
            if (busReq & ~phase_reg & avsRead) begin
                case (avsAddress)
                    `TWTT_REG_CTRL: avsReadData <= {30'h0, ctrl_reg};
                    `TWTT_REG_OWN_ADDR: avsReadData <= {25'h0, ownAddr_reg};
                    `TWTT_REG_STATUS: avsReadData <= {24'h000000, statusBits};
                    `TWTT_REG_RX_HOLD: avsReadData <= {24'h000000, rxHold_reg};
                    `TWTT_REG_IRQ_STATUS: avsReadData <= {26'h0, irqStatus_reg};
                    `TWTT_REG_IRQ_ENABLE: avsReadData <= {26'h0, irqEnable_reg};
                    default: avsReadData <= 32'h00000000;
                endcase
            end
            if (busDone & avsWrite) begin
                case (avsAddress)
                    `TWTT_REG_CTRL: ctrl_reg <= avsWriteData[1:0];
                    `TWTT_REG_OWN_ADDR: ownAddr_reg <= avsWriteData[6:0];
                    `TWTT_REG_IRQ_ENABLE: irqEnable_reg <= avsWriteData[`TWTT_EV_WIDTH-1:0];
                    default: ;
                endcase
            end
            evPrev_reg <= evNow;
            // New events win over a clear in the same cycle
            irqStatus_reg <= (irqStatus_reg & ~irqClear) | evRise;
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rxHold_reg <= 8'h00;
            txHold_reg <= 8'h00;
            rxFull_reg <= 1'b0;
            txFull_reg <= 1'b0;
            readDir_reg <= 1'b0;
            access_reg <= 1'b0;
            xferDone_reg <= 1'b0;
            clkWait_reg <= 1'b0;
            genCall_reg <= 1'b0;
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bitCnt_reg <= 3'h0;
            ackOn_reg <= 1'b0;
            rxPend_reg <= 1'b0;
            masterNack_reg <= 1'b0;
            sclDrive_reg <= 1'b0;
            sdaDrive_reg <= 1'b0;
        end else begin
            if (rdRxHold) begin
                rxFull_reg <= 1'b0;
            end
            if (wrTxHold) begin
                txHold_reg <= avsWriteData[7:0];
                txFull_reg <= 1'b1;
            end
            if (!ctrl_reg[`TWTT_CTRL_ENABLE]) begin
                state_reg <= ST_IDLE;
                access_reg <= 1'b0;
                clkWait_reg <= 1'b0;
                sclDrive_reg <= 1'b0;
                sdaDrive_reg <= 1'b0;
            end else if (stopDet) begin
                if (access_reg) begin
                    xferDone_reg <= 1'b1;
                end
                access_reg <= 1'b0;
                clkWait_reg <= 1'b0;
                sclDrive_reg <= 1'b0;
                sdaDrive_reg <= 1'b0;
                rxPend_reg <= 1'b0;
                state_reg <= ST_IDLE;
            end else if (startDet) begin
                state_reg <= ST_ADDR;
                bitCnt_reg <= 3'h0;
                genCall_reg <= 1'b0;
                clkWait_reg <= 1'b0;
                sclDrive_reg <= 1'b0;
                sdaDrive_reg <= 1'b0;
                rxPend_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR: begin
                        if (sclRise) begin
                            shift_reg <= {shift_reg[6:0], sdaLvl};
                            bitCnt_reg <= bitCnt_reg + 3'h1;
                            if (bitCnt_reg == 3'h7) begin
                                if (addrHit(shift_reg[6:0], ownAddr_reg)) begin
                                    access_reg <= 1'b1;
                                    readDir_reg <= sdaLvl;
                                    xferDone_reg <= 1'b0;
                                    ackOn_reg <= 1'b0;
                                    state_reg <= ST_ACK;
                                end else if (ctrl_reg[`TWTT_CTRL_GC_ENABLE] & ~sdaLvl &
                                    addrHit(shift_reg[6:0], `TWTT_GEN_CALL_ADDR)) begin
                                    access_reg <= 1'b1;
                                    readDir_reg <= 1'b0;
                                    genCall_reg <= 1'b1;
                                    xferDone_reg <= 1'b0;
                                    ackOn_reg <= 1'b0;
                                    state_reg <= ST_ACK;
                                end else begin
                                    if (access_reg) begin
                                        xferDone_reg <= 1'b1;
                                    end
                                    access_reg <= 1'b0;
                                    state_reg <= ST_IDLE;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (!ackOn_reg) begin
                            if (sclFall | sclDrive_reg) begin
                                if (rxPend_reg & rxFull_reg & ~rdRxHold) begin
                                    sclDrive_reg <= 1'b1;
                                    clkWait_reg <= 1'b1;
                                end else begin
                                    if (rxPend_reg) begin
                                        rxHold_reg <= shift_reg;
                                        rxFull_reg <= 1'b1;
                                        rxPend_reg <= 1'b0;
                                    end
                                    sdaDrive_reg <= 1'b1;
                                    ackOn_reg <= 1'b1;
                                end
                            end
                        end else begin
                            // Clock freed a cycle after the acknowledge settles
                            sclDrive_reg <= 1'b0;
                            clkWait_reg <= 1'b0;
                            if (sclFall) begin
                                sdaDrive_reg <= 1'b0;
                                ackOn_reg <= 1'b0;
                                bitCnt_reg <= 3'h0;
                                state_reg <= readDir_reg ? ST_TXLOAD : ST_RX;
                            end
                        end
                    end
                    ST_RX: begin
                        if (sclRise) begin
                            shift_reg <= {shift_reg[6:0], sdaLvl};
                            bitCnt_reg <= bitCnt_reg + 3'h1;
                            if (bitCnt_reg == 3'h7) begin
                                // Byte lands at once when the holding register is free
                                if (!rxFull_reg | rdRxHold) begin
                                    rxHold_reg <= {shift_reg[6:0], sdaLvl};
                                    rxFull_reg <= 1'b1;
                                end else begin
                                    rxPend_reg <= 1'b1;
                                end
                                state_reg <= ST_ACK;
                            end
                        end
                    end
                    ST_TXLOAD: begin
                        if (txFull_reg) begin
                            shift_reg <= txHold_reg;
                            txFull_reg <= wrTxHold;
                            sdaDrive_reg <= ~txHold_reg[7];
                            bitCnt_reg <= 3'h0;
                            state_reg <= ST_TX;
                        end else begin
                            sclDrive_reg <= 1'b1;
                            clkWait_reg <= 1'b1;
                        end
                    end
                    ST_TX: begin
                        sclDrive_reg <= 1'b0;
                        clkWait_reg <= 1'b0;
                        if (sclFall) begin
                            bitCnt_reg <= bitCnt_reg + 3'h1;
                            if (bitCnt_reg == 3'h7) begin
                                sdaDrive_reg <= 1'b0;
                                state_reg <= ST_TXACK;
                            end else begin
                                sdaDrive_reg <= ~shift_reg[6];
                                shift_reg <= {shift_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (sclRise) begin
                            masterNack_reg <= sdaLvl;
                        end
                        if (sclFall) begin
                            // Keep sending until the controller ends the read
                            state_reg <= masterNack_reg ? ST_WAITEND : ST_TXLOAD;
                        end
                    end
                    ST_WAITEND: begin
                        sdaDrive_reg <= 1'b0;
                    end
                    default: begin
                        sclDrive_reg <= 1'b0;
                        sdaDrive_reg <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
